// File: rtl/comparator_pkg.sv
package comparator_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CH_W = 3;
  // Device register addresses
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_PIN_DIS = 3'h1;
  localparam logic [2:0] ADDR_CONV_B = 3'h2;
  localparam logic [2:0] ADDR_CONV_MUX = 3'h3;
  localparam logic [2:0] ADDR_CONV_A = 3'h4;
  // Comparator control bits
  localparam int CTRL_POWER_OFF = 7;
  localparam int CTRL_BANDGAP = 6;
  localparam int CTRL_RESULT = 5;
  localparam int CTRL_FLAG = 4;
  localparam int CTRL_IE = 3;
  localparam int CTRL_ROUTE = 2;
  localparam int MODE_LSB = 0;
  localparam int CONVB_MUX_EN = 6;
  localparam int CONVA_ENABLE = 7;
  localparam int MUX_CH_LSB = 0;
  localparam int PIN_NEG_OFF = 1;
  localparam int PIN_POS_OFF = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'h0,
    MODE_RSVD = 2'h1,
    MODE_FALL = 2'h2,
    MODE_RISE = 2'h3
  } irq_mode_t;
  // Controller APB map
  localparam logic [11:0] APB_COMP_CFG = 12'h000;
  localparam logic [11:0] APB_ANALOG_CFG = 12'h004;
  localparam logic [11:0] APB_STATUS = 12'h008;
  localparam logic [11:0] APB_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] APB_IRQ_MASK = 12'h010;
  localparam int HCFG_GLOBAL_IE = 8;
  localparam int AN_MUX_EN = 2;
  localparam int AN_CHAN_LSB = 4;
  localparam int AN_CONV_EN = 7;
  localparam int STATUS_BUSY = 8;
  localparam int IRQ_COMP = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_W = 2;
endpackage : comparator_pkg

// File: rtl/comparator_link_if.sv
`timescale 1ns/1ps
interface comparator_link_if;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic irq;
  logic irq_ack;
  logic global_irq_enable;
  modport dev (
    input reg_addr, reg_wdata, reg_wr, reg_rd, irq_ack, global_irq_enable,
    output reg_rdata, irq
  );
  modport ctl (
    output reg_addr, reg_wdata, reg_wr, reg_rd, irq_ack, global_irq_enable,
    input reg_rdata, irq
  );
endinterface : comparator_link_if

// File: rtl/two_flop_sync.sv
`timescale 1ns/1ps
module two_flop_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : two_flop_sync

// File: rtl/comparator_control.sv
// Functional notes
// RULE1: Mux feeds negative input when enabled, converter off
// RULE2: Channel field picks converter pin zero..seven
// RULE3: Power-off bit switches comparator off, resets zero
// RULE4: Software drops interrupt enable before power change
// RULE5: Bandgap select drives positive input
// RULE6: Result bit read-only, synchronized, one-two cycles
// RULE7: Matching output event sets interrupt flag
// RULE8: Request needs flag, enable and global enable
// RULE9: Flag clears on vector taken or write-one
// RULE10: Mode: toggle, reserved, falling, rising
// RULE11: Software drops interrupt enable before mode change
// RULE12: Route bit feeds result to capture front end
// RULE13: Software sets timer capture interrupt enable
// RULE14: Digital-off bit kills buffer, pin reads zero
// RULE15: Software sets digital-off for analog pins
// RULE16: Result high when positive exceeds negative
// RULE17: Converter enable bit turns converter on
// RULE18: Upper digital-off bits read zero
`timescale 1ns/1ps
module comparator_control (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to controller
  comparator_link_if.dev link,
  // Analog front end
  input wire logic comp_raw,
  input wire logic pos_pin_level,
  input wire logic neg_pin_level,
  output logic comp_power_off,
  output logic bandgap_positive_select,
  output logic neg_from_mux,
  output logic [2:0] neg_mux_channel,
  output logic converter_power_on,
  // Timer capture front end
  output logic capture_input,
  // Pin buffers
  output logic pos_pin_buf_on,
  output logic neg_pin_buf_on,
  output logic pos_pin_read,
  output logic neg_pin_read
);
  ////////////////////////////////////////////////////////////////////////////////
  logic power_off_reg;
  logic bandgap_reg;
  logic flag_reg;
  logic ie_reg;
  logic route_reg;
  logic [1:0] mode_reg;
  logic [1:0] pin_off_reg;
  logic mux_en_reg;
  logic [2:0] channel_reg;
  logic conv_en_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic neg_mux_reg;
  logic capture_reg;
  logic pos_read_reg;
  logic neg_read_reg;
  logic prev_reg;
  logic [2:0] sync_q;
  logic result;
  logic rise;
  logic fall;
  logic event_hit;
  logic wr_ctrl;
  logic [7:0] ctrl_view;

  assign wr_ctrl = link.reg_wr && (link.reg_addr == comparator_pkg::ADDR_CTRL);

  ////////////////////////////////////////////////////////////////////////////////
  // RULE16: raw result input
  two_flop_sync #(.WIDTH(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({neg_pin_level, pos_pin_level, comp_raw}),
    .q(sync_q)
  );

  // RULE6: synchronized result
  // Gated after the sync, so the raw pin meets no logic first
  assign result = sync_q[0] && !power_off_reg;
  assign rise = result && !prev_reg;
  assign fall = !result && prev_reg;

  // RULE10: mode decode
  always_comb begin
    unique case (comparator_pkg::irq_mode_t'(mode_reg))
      comparator_pkg::MODE_TOGGLE: event_hit = rise || fall;
      comparator_pkg::MODE_RSVD: event_hit = 1'b0;
      comparator_pkg::MODE_FALL: event_hit = fall;
      comparator_pkg::MODE_RISE: event_hit = rise;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_off_reg <= 1'b0;
      bandgap_reg <= 1'b0;
      ie_reg <= 1'b0;
      route_reg <= 1'b0;
      mode_reg <= comparator_pkg::MODE_TOGGLE;
    end else if (wr_ctrl) begin
      // RULE3: power-off bit
      power_off_reg <= link.reg_wdata[comparator_pkg::CTRL_POWER_OFF];
      // RULE5: bandgap select
      bandgap_reg <= link.reg_wdata[comparator_pkg::CTRL_BANDGAP];
      ie_reg <= link.reg_wdata[comparator_pkg::CTRL_IE];
      route_reg <= link.reg_wdata[comparator_pkg::CTRL_ROUTE];
      mode_reg <= link.reg_wdata[comparator_pkg::MODE_LSB +: 2];
    end
  end

  // Set wins over either clear so an event in the clear cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    // RULE7: event sets flag
    end else if (event_hit) begin
      flag_reg <= 1'b1;
    // RULE9: vector or write-one clears
    end else if (link.irq_ack || (wr_ctrl && link.reg_wdata[comparator_pkg::CTRL_FLAG])) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_off_reg <= 2'h0;
    end else if (link.reg_wr && link.reg_addr == comparator_pkg::ADDR_PIN_DIS) begin
      pin_off_reg <= link.reg_wdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_en_reg <= 1'b0;
      channel_reg <= 3'h0;
      conv_en_reg <= 1'b0;
    end else if (link.reg_wr) begin
      if (link.reg_addr == comparator_pkg::ADDR_CONV_B) begin
        mux_en_reg <= link.reg_wdata[comparator_pkg::CONVB_MUX_EN];
      end
      if (link.reg_addr == comparator_pkg::ADDR_CONV_MUX) begin
        channel_reg <= link.reg_wdata[comparator_pkg::MUX_CH_LSB +: comparator_pkg::CH_W];
      end
      if (link.reg_addr == comparator_pkg::ADDR_CONV_A) begin
        conv_en_reg <= link.reg_wdata[comparator_pkg::CONVA_ENABLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read-back, valid the cycle after the read strobe
  always_comb begin
    ctrl_view = comparator_pkg::REG_RESET;
    ctrl_view[comparator_pkg::CTRL_POWER_OFF] = power_off_reg;
    ctrl_view[comparator_pkg::CTRL_BANDGAP] = bandgap_reg;
    ctrl_view[comparator_pkg::CTRL_RESULT] = result;
    ctrl_view[comparator_pkg::CTRL_FLAG] = flag_reg;
    ctrl_view[comparator_pkg::CTRL_IE] = ie_reg;
    ctrl_view[comparator_pkg::CTRL_ROUTE] = route_reg;
    ctrl_view[comparator_pkg::MODE_LSB +: 2] = mode_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= comparator_pkg::REG_RESET;
    end else if (link.reg_rd) begin
      unique case (link.reg_addr)
        comparator_pkg::ADDR_CTRL: rdata_reg <= ctrl_view;
        // RULE18: upper bits zero
        comparator_pkg::ADDR_PIN_DIS: rdata_reg <= {6'h00, pin_off_reg};
        comparator_pkg::ADDR_CONV_B: rdata_reg <= {1'b0, mux_en_reg, 6'h00};
        comparator_pkg::ADDR_CONV_MUX: rdata_reg <= {5'h00, channel_reg};
        comparator_pkg::ADDR_CONV_A: rdata_reg <= {conv_en_reg, 7'h00};
        default: rdata_reg <= comparator_pkg::REG_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs, one cycle behind their controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
      neg_mux_reg <= 1'b0;
      capture_reg <= 1'b0;
      pos_read_reg <= 1'b0;
      neg_read_reg <= 1'b0;
    end else begin
      // RULE8: three-way gate
      irq_reg <= flag_reg && ie_reg && link.global_irq_enable;
      // RULE1: mux only with converter off
      neg_mux_reg <= mux_en_reg && !conv_en_reg;
      // RULE12: capture routing
      capture_reg <= route_reg && result;
      // RULE14: disabled pins read zero
      pos_read_reg <= sync_q[1] && !pin_off_reg[comparator_pkg::PIN_POS_OFF];
      neg_read_reg <= sync_q[2] && !pin_off_reg[comparator_pkg::PIN_NEG_OFF];
    end
  end

  assign link.reg_rdata = rdata_reg;
  assign link.irq = irq_reg;
  assign comp_power_off = power_off_reg;
  assign bandgap_positive_select = bandgap_reg;
  assign neg_from_mux = neg_mux_reg;
  // RULE2: channel to mux
  assign neg_mux_channel = channel_reg;
  // RULE17: converter power
  assign converter_power_on = conv_en_reg;
  assign capture_input = capture_reg;
  assign pos_pin_buf_on = !pin_off_reg[comparator_pkg::PIN_POS_OFF];
  assign neg_pin_buf_on = !pin_off_reg[comparator_pkg::PIN_NEG_OFF];
  assign pos_pin_read = pos_read_reg;
  assign neg_pin_read = neg_read_reg;
endmodule : comparator_control

// File: rtl/comparator_host.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module comparator_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt and timer side
  output logic irq,
  output logic timer_capture_irq_enable,
  // Link to comparator
  comparator_link_if.ctl link
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_POLL, ST_POLL_WAIT, ST_POLL_TAKE,
    ST_CFG_OFF, ST_CFG_NEW, ST_CFG_ON,
    ST_AN_PIN, ST_AN_B, ST_AN_MUX, ST_AN_A, ST_AN_READ
  } host_state_t;

  host_state_t state_reg;
  logic [8:0] cfg_req_reg;
  logic [7:0] applied_reg;
  logic cfg_pend_reg;
  logic [7:0] an_req_reg;
  logic an_pend_reg;
  logic [7:0] status_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic irq_reg;
  logic cap_ie_reg;
  logic gie_reg;
  logic [2:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_reg;
  logic rd_reg;
  logic ack_reg;
  logic ack_wait_reg;
  logic apb_wr;
  logic apb_rd;
  logic done;
  logic [7:0] cfg_off;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign done = (state_reg == ST_CFG_ON) || (state_reg == ST_AN_A);
  assign cfg_off = cfg_req_reg[7:0] & ~(8'h01 << comparator_pkg::CTRL_IE);

  ////////////////////////////////////////////////////////////////////////////////
  // APB registers; a new request while one of the same kind is pending is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_req_reg <= 9'h000;
      cfg_pend_reg <= 1'b0;
      an_req_reg <= 8'h00;
      an_pend_reg <= 1'b0;
      irq_mask_reg <= 2'h0;
    end else begin
      if (apb_wr && paddr == comparator_pkg::APB_COMP_CFG && !cfg_pend_reg) begin
        cfg_req_reg <= pwdata[8:0];
        cfg_pend_reg <= 1'b1;
      end else if (state_reg == ST_CFG_ON) begin
        cfg_pend_reg <= 1'b0;
      end
      if (apb_wr && paddr == comparator_pkg::APB_ANALOG_CFG && !an_pend_reg) begin
        an_req_reg <= pwdata[7:0];
        an_pend_reg <= 1'b1;
      end else if (state_reg == ST_AN_A) begin
        an_pend_reg <= 1'b0;
      end
      if (apb_wr && paddr == comparator_pkg::APB_IRQ_MASK) begin
        irq_mask_reg <= pwdata[1:0];
      end
    end
  end

  // Set wins over the write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= 2'h0;
    end else begin
      for (int i = 0; i < comparator_pkg::IRQ_W; i++) begin
        if ((i == comparator_pkg::IRQ_COMP && ack_reg) || (i == comparator_pkg::IRQ_DONE && done)) begin
          irq_status_reg[i] <= 1'b1;
        end else if (apb_wr && paddr == comparator_pkg::APB_IRQ_STATUS && pwdata[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      irq_reg <= |(irq_status_reg & irq_mask_reg);
      if (apb_rd) begin
        unique case (paddr)
          comparator_pkg::APB_COMP_CFG: prdata_reg <= {23'h000000, cfg_req_reg};
          comparator_pkg::APB_ANALOG_CFG: prdata_reg <= {24'h000000, an_req_reg};
          comparator_pkg::APB_STATUS:
            prdata_reg <= {23'h000000, cfg_pend_reg | an_pend_reg, status_reg};
          comparator_pkg::APB_IRQ_STATUS: prdata_reg <= {30'h00000000, irq_status_reg};
          comparator_pkg::APB_IRQ_MASK: prdata_reg <= {30'h00000000, irq_mask_reg};
          default: prdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer; idle time polls the comparator control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      addr_reg <= comparator_pkg::ADDR_CTRL;
      wdata_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      status_reg <= 8'h00;
      applied_reg <= 8'h00;
      cap_ie_reg <= 1'b0;
      gie_reg <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (cfg_pend_reg) begin
            state_reg <= ST_CFG_OFF;
          end else if (an_pend_reg) begin
            state_reg <= ST_AN_PIN;
          end else begin
            state_reg <= ST_POLL;
          end
        end
        ST_POLL: begin
          addr_reg <= comparator_pkg::ADDR_CTRL;
          rd_reg <= 1'b1;
          state_reg <= ST_POLL_WAIT;
        end
        ST_POLL_WAIT: state_reg <= ST_POLL_TAKE;
        ST_POLL_TAKE: begin
          status_reg <= link.reg_rdata;
          state_reg <= ST_IDLE;
        end
        // RULE4: enable dropped before power change
        // RULE11: enable dropped before mode change
        ST_CFG_OFF: begin
          addr_reg <= comparator_pkg::ADDR_CTRL;
          wdata_reg <= applied_reg & ~(8'h03 << comparator_pkg::CTRL_IE);
          wr_reg <= 1'b1;
          state_reg <= ST_CFG_NEW;
        end
        // Clears any flag raised before this write, not one the new settings raise
        ST_CFG_NEW: begin
          wdata_reg <= cfg_off | (8'h01 << comparator_pkg::CTRL_FLAG);
          wr_reg <= 1'b1;
          state_reg <= ST_CFG_ON;
        end
        ST_CFG_ON: begin
          wdata_reg <= cfg_req_reg[7:0] & ~(8'h01 << comparator_pkg::CTRL_FLAG);
          wr_reg <= 1'b1;
          applied_reg <= cfg_req_reg[7:0];
          gie_reg <= cfg_req_reg[comparator_pkg::HCFG_GLOBAL_IE];
          // RULE13: timer capture enable follows route
          cap_ie_reg <= cfg_req_reg[comparator_pkg::CTRL_ROUTE];
          state_reg <= ST_IDLE;
        end
        // RULE15: analog pins get digital-off
        ST_AN_PIN: begin
          addr_reg <= comparator_pkg::ADDR_PIN_DIS;
          wdata_reg <= {6'h00, an_req_reg[1:0]};
          wr_reg <= 1'b1;
          state_reg <= ST_AN_B;
        end
        ST_AN_B: begin
          addr_reg <= comparator_pkg::ADDR_CONV_B;
          wdata_reg <= {7'h00, an_req_reg[comparator_pkg::AN_MUX_EN]} << comparator_pkg::CONVB_MUX_EN;
          wr_reg <= 1'b1;
          state_reg <= ST_AN_MUX;
        end
        ST_AN_MUX: begin
          addr_reg <= comparator_pkg::ADDR_CONV_MUX;
          wdata_reg <= {5'h00, an_req_reg[comparator_pkg::AN_CHAN_LSB +: comparator_pkg::CH_W]};
          wr_reg <= 1'b1;
          state_reg <= ST_AN_A;
        end
        ST_AN_A: begin
          addr_reg <= comparator_pkg::ADDR_CONV_A;
          wdata_reg <= {an_req_reg[comparator_pkg::AN_CONV_EN], 7'h00};
          wr_reg <= 1'b1;
          state_reg <= ST_AN_READ;
        end
        // Read back the disable register once
        ST_AN_READ: begin
          addr_reg <= comparator_pkg::ADDR_PIN_DIS;
          rd_reg <= 1'b1;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Vector taken once per request; waits for the request to fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
      ack_wait_reg <= 1'b0;
    end else begin
      ack_reg <= link.irq && !ack_wait_reg && !ack_reg;
      if (ack_reg) begin
        ack_wait_reg <= 1'b1;
      end else if (!link.irq) begin
        ack_wait_reg <= 1'b0;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = 1'b0 & pready_reg;
  assign irq = irq_reg;
  assign timer_capture_irq_enable = cap_ie_reg;
  assign link.reg_addr = addr_reg;
  assign link.reg_wdata = wdata_reg;
  assign link.reg_wr = wr_reg;
  assign link.reg_rd = rd_reg;
  assign link.irq_ack = ack_reg;
  assign link.global_irq_enable = gie_reg;
endmodule : comparator_host

// File: sim/comparator_link_asserts.sv
`timescale 1ns/1ps
module comparator_link_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic irq_ack,
  input wire logic global_irq_enable,
  // Analog side
  input wire logic comp_power_off,
  input wire logic bandgap_positive_select,
  input wire logic neg_from_mux,
  input wire logic [2:0] neg_mux_channel,
  input wire logic converter_power_on,
  input wire logic capture_input,
  input wire logic pos_pin_buf_on,
  input wire logic neg_pin_buf_on
);
  logic [7:0] ctrl_reg, pin_reg, convb_reg, mux_reg, conva_reg;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of device registers, built only from link writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 8'h00;
      pin_reg <= 8'h00;
      convb_reg <= 8'h00;
      mux_reg <= 8'h00;
      conva_reg <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        comparator_pkg::ADDR_CTRL: ctrl_reg <= reg_wdata;
        comparator_pkg::ADDR_PIN_DIS: pin_reg <= reg_wdata;
        comparator_pkg::ADDR_CONV_B: convb_reg <= reg_wdata;
        comparator_pkg::ADDR_CONV_MUX: mux_reg <= reg_wdata;
        comparator_pkg::ADDR_CONV_A: conva_reg <= reg_wdata;
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_irq_gate;
    irq |-> $past(global_irq_enable) && $past(ctrl_reg[3]);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq raised without both enables");
  // Ack clears the flag; irq register follows one edge later
  property p_ack_clear;
    irq_ack |-> ##2 !irq;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("irq still high after ack");
  property p_mux_path;
    neg_from_mux == $past(convb_reg[6] && !conva_reg[7]);
  endproperty
  a_mux_path: assert property (p_mux_path)
    else $error("negative input path wrong");
  property p_channel;
    neg_from_mux && $stable(mux_reg) |-> neg_mux_channel == mux_reg[2:0];
  endproperty
  a_channel: assert property (p_channel)
    else $error("mux channel mismatch");
  property p_power;
    $stable(ctrl_reg) |-> comp_power_off == ctrl_reg[7];
  endproperty
  a_power: assert property (p_power)
    else $error("power off bit not applied");
  property p_bandgap;
    $stable(ctrl_reg) |-> bandgap_positive_select == ctrl_reg[6];
  endproperty
  a_bandgap: assert property (p_bandgap)
    else $error("bandgap select not applied");
  property p_pin_buf;
    $stable(pin_reg) |-> {neg_pin_buf_on, pos_pin_buf_on} == ~pin_reg[1:0];
  endproperty
  a_pin_buf: assert property (p_pin_buf)
    else $error("pin buffer enable wrong");
  property p_upper_zero;
    reg_rd && reg_addr == comparator_pkg::ADDR_PIN_DIS |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unused disable bits read nonzero");
  property p_capture;
    !$past(ctrl_reg[2]) |-> !capture_input;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture input driven while unrouted");
  property p_conv_on;
    $stable(conva_reg) |-> converter_power_on == conva_reg[7];
  endproperty
  a_conv_on: assert property (p_conv_on)
    else $error("converter enable not applied");
  c_irq: cover property ($rose(irq));
  c_mux: cover property ($rose(neg_from_mux));
  c_capture: cover property ($rose(capture_input));
endmodule : comparator_link_asserts

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, timer_capture_irq_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic comp_raw, pos_pin_level, neg_pin_level, comp_power_off, bandgap_positive_select;
  logic neg_from_mux, converter_power_on, capture_input;
  logic pos_pin_buf_on, neg_pin_buf_on, pos_pin_read, neg_pin_read;
  logic [2:0] neg_mux_channel;
  int num_errors, checked;
  comparator_link_if link();
  comparator_control comparator_control_inst (.pclk(pclk), .presetn(presetn), .link(link.dev),
    .comp_raw(comp_raw), .pos_pin_level(pos_pin_level), .neg_pin_level(neg_pin_level),
    .comp_power_off(comp_power_off), .bandgap_positive_select(bandgap_positive_select),
    .neg_from_mux(neg_from_mux), .neg_mux_channel(neg_mux_channel),
    .converter_power_on(converter_power_on), .capture_input(capture_input),
    .pos_pin_buf_on(pos_pin_buf_on), .neg_pin_buf_on(neg_pin_buf_on),
    .pos_pin_read(pos_pin_read), .neg_pin_read(neg_pin_read));
  comparator_host comparator_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .timer_capture_irq_enable(timer_capture_irq_enable), .link(link.ctl));
  comparator_link_asserts comparator_link_asserts_inst (.pclk(pclk), .presetn(presetn),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr),
    .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .irq(link.irq), .irq_ack(link.irq_ack),
    .global_irq_enable(link.global_irq_enable), .comp_power_off(comp_power_off),
    .bandgap_positive_select(bandgap_positive_select), .neg_from_mux(neg_from_mux),
    .neg_mux_channel(neg_mux_channel), .converter_power_on(converter_power_on),
    .capture_input(capture_input), .pos_pin_buf_on(pos_pin_buf_on),
    .neg_pin_buf_on(neg_pin_buf_on));
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  // Answer taken at the rising edge that sees pready, then released
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & mask, exp);
  endtask : rd_chk
  // Host drops a config write while that same request is still pending, so every config waits for idle
  task cfg(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    do begin
      settle(2);
      apb(1'b0, comparator_pkg::APB_STATUS, 32'h0);
    end while (rd[comparator_pkg::STATUS_BUSY] !== 1'b0);
    settle(4);
  endtask : cfg
  task edge_chk(input logic lvl, input logic exp);
    @(posedge pclk);
    comp_raw <= lvl;
    settle(30);
    rd_chk(comparator_pkg::APB_IRQ_STATUS, 32'h1, {31'h0, exp});
    settle(0);
    chk({31'h0, irq}, {31'h0, exp});
    apb(1'b1, comparator_pkg::APB_IRQ_STATUS, 32'h3);
  endtask : edge_chk
  task wrap_up;
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; comp_raw = 1'b0; pos_pin_level = 1'b1; neg_pin_level = 1'b1;
    num_errors = 0; checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
    chk({30'h0, comp_power_off, bandgap_positive_select}, 32'h0);
    rd_chk(12'h020, 32'hffffffff, 32'h0);
    rd_chk(comparator_pkg::APB_COMP_CFG, 32'h1ff, 32'h0);
    for (int k = 0; k < 8; k++) begin
      cfg(comparator_pkg::APB_ANALOG_CFG, 32'h4 | (32'(k) << 4));
      chk({31'h0, neg_from_mux}, 32'h1);
      chk({29'h0, neg_mux_channel}, 32'(k));
    end
    @(posedge pclk);
    neg_pin_level <= 1'b0;
    cfg(comparator_pkg::APB_ANALOG_CFG, 32'h84);
    chk({30'h0, neg_from_mux, converter_power_on}, 32'h1);
    chk({28'h0, pos_pin_buf_on, neg_pin_buf_on, pos_pin_read, neg_pin_read}, 32'he);
    cfg(comparator_pkg::APB_ANALOG_CFG, 32'h03);
    chk({28'h0, pos_pin_buf_on, neg_pin_buf_on, pos_pin_read, neg_pin_read}, 32'h0);
    rd_chk(comparator_pkg::APB_IRQ_STATUS, 32'h2, 32'h2);
    apb(1'b1, comparator_pkg::APB_IRQ_MASK, 32'h1);
    for (int m = 0; m < 4; m++) begin
      cfg(comparator_pkg::APB_COMP_CFG, 32'h108 | 32'(m));
      apb(1'b1, comparator_pkg::APB_IRQ_STATUS, 32'h3);
      edge_chk(1'b1, m == 0 || m == 3);
      edge_chk(1'b0, m == 0 || m == 2);
    end
    cfg(comparator_pkg::APB_COMP_CFG, 32'h008);
    apb(1'b1, comparator_pkg::APB_IRQ_STATUS, 32'h3);
    edge_chk(1'b1, 1'b0);
    cfg(comparator_pkg::APB_COMP_CFG, 32'h004);
    settle(10);
    chk({29'h0, pslverr, timer_capture_irq_enable, capture_input}, 32'h3);
    rd_chk(comparator_pkg::APB_STATUS, 32'h20, 32'h20);
    cfg(comparator_pkg::APB_COMP_CFG, 32'h0c0);
    settle(10);
    chk({30'h0, timer_capture_irq_enable, capture_input}, 32'h0);
    chk({30'h0, comp_power_off, bandgap_positive_select}, 32'h3);
    rd_chk(comparator_pkg::APB_STATUS, 32'h20, 32'h0);
    wrap_up();
  end
  // Whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
endmodule : testbench
